// File: inc/daisy_link_params.svh
// constants of the daisy-chain link engine: opcodes, fields, timing
`ifndef DAISY_LINK_PARAMS_SVH
`define DAISY_LINK_PARAMS_SVH
`define OP_ADDR_INIT 8'h95
`define OP_LAST_POLL 8'h57
`define OP_SOFT_RESET 8'h5D
`define OP_ALERT_CLR1 8'hB5
`define OP_ALERT_CLR2 8'h75
`define CFG_PTR 4'h1
`define CFG_SRST_BIT 1
`define CFG_ONESHOT_BIT 12
`define RESP_TAG 3'h0
`define PINS_RST 4'hB
`define CLK_MHZ 200
`define T_RESP_US 7000
`define T_INIT_TO_US 1000000
`define T_GREAD_TO_US 35000
`define BIT_W 16
`define TMR_W 28
`endif

// File: inc/daisy_link_pkg.sv
// types shared by the daisy-chain link engine
`include "daisy_link_params.svh"
package daisy_link_pkg;
  typedef enum logic [1:0] {R_CALW, R_CALM, R_IDLE, R_BITS} rx_st_t;
  typedef enum logic [3:0] {P_OP, P_PTR, P_D0, P_D1, P_FWD, P_RLO, P_RHI,
    P_TXW, P_INIT, P_INITW, P_INITD, P_INITF} eng_st_t;
  // opcode byte, msb first: field, type, read, global
  typedef struct packed {
    logic [4:0] node_address_field;
    logic operation_type_bit;
    logic read_not_write_bit;
    logic global_select_bit;
  } opcode_t;
  typedef struct packed {
    rx_st_t st;
    logic [`BIT_W+2:0] cnt;
    logic [`BIT_W-1:0] bitp;
    logic [3:0] n;
    logic [2:0] falls;
    logic [7:0] sh;
    logic prev;
  } rx_t;
  typedef struct packed {
    logic busy;
    logic dn;
    logic [3:0] n;
    logic [`BIT_W-1:0] cnt;
    logic [9:0] sh;
  } tx_t;
  typedef struct packed {
    logic [`BIT_W+3:0] gap;
    logic [5:0] words;
    logic prev;
  } dnmon_t;
  typedef struct packed {
    eng_st_t st;
    opcode_t op;
    logic [3:0] ptr;
    logic [7:0] lo;
    logic [15:0] wdata;
    logic [`TMR_W-1:0] tmr;
    logic [4:0] addr;
    logic last;
    logic dir_up;
    logic own;
    logic [5:0] need;
    logic cbusy;
    logic wr;
    logic srst;
    logic aclr;
    logic conv;
  } eng_t;
  typedef struct packed {
    logic up_tx;
    logic up_oe;
    logic dn_tx;
    logic dn_oe;
  } pin_t;
endpackage : daisy_link_pkg

// File: verilog/daisy_chain_sensor_link.sv
// daisy-chain sensor node link engine and its receive byte fifo
//
// What this block does
// - type bit 1 command, 0 address; rw selects
// - five bits above type bit are address
// - pointer byte only in address operations
// - data phase two bytes, low byte first
// - writes store host data, reads return register
// - uninvolved node repeats traffic both directions
// - init: store address, respond once after 7 ms
// - stalled init released after one second
// - last init node answers poll with address
// - other nodes never answer last poll
// - software reset command reloads and clears
// - read reply starts within 1.5 bit times
// - global write hits nodes up to address
// - global read replies addressed node down
// - global read beyond chain ends at 35 ms
// - continuous conversion is default mode
// - shutdown keeps link and registers working
// - shutdown plus trigger bit: one conversion
// - trigger bit always reads back zero
// - idle high, 10-bit words, lsb first
// - each operation starts with 55h calibration
// - opcode layout and command code values
// - global bit set for commands and globals
`timescale 1ns/1ps
`default_nettype none
`include "daisy_link_params.svh"

module byte_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  // depth must be a power of two so the pointers wrap by themselves
  always_comb begin
    in_ready = cnt_r != (AW+1)'(D);
    out_valid = cnt_r != '0;
    out_data = mem[rp_r];
    push = in_valid & in_ready;
    pop = out_ready & out_valid;
    wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + push - pop);
  end
  // pointers, count and storage
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push) begin
        mem[wp_r] <= in_data;
      end
    end
  end
endmodule : byte_fifo

module daisy_chain_sensor_link #(
  parameter int RESP_CYC = `T_RESP_US * `CLK_MHZ,
  parameter int INIT_TO_CYC = `T_INIT_TO_US * `CLK_MHZ,
  parameter int GREAD_TO_CYC = `T_GREAD_TO_US * `CLK_MHZ,
  parameter int FIFO_D = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic UP_RX,
  output logic UP_TX,
  output logic UP_OE,
  input wire logic DN_RX,
  output logic DN_TX,
  output logic DN_OE,
  input wire logic SHUTDOWN,
  input wire logic CONV_DONE,
  input wire logic [15:0] REG_RDATA,
  output logic [3:0] REG_PTR,
  output logic [15:0] REG_WDATA,
  output logic REG_WR,
  output logic SOFT_RST,
  output logic ALERT_CLR,
  output logic CONV_START,
  output logic [4:0] NODE_ADDR,
  output logic LAST_NODE
);
  daisy_link_pkg::rx_t rx_r, rx_nxt;
  daisy_link_pkg::tx_t tx_r, tx_nxt;
  daisy_link_pkg::dnmon_t dn_r, dn_nxt;
  daisy_link_pkg::eng_t eng_r, eng_nxt;
  daisy_link_pkg::pin_t pins_r, pins_nxt;
  daisy_link_pkg::opcode_t opc;
  logic push, fifo_rdy, fv, pop, cal, go, god, own_up, own_dn;
  logic up_fall, dn_fall, mine, part, hit;
  logic [7:0] fd, gob;
  logic [15:0] rdm;
  logic [`BIT_W+3:0] gap_len;

  byte_fifo #(.W(8), .D(FIFO_D)) rx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .in_valid(push),
    .in_data(rx_r.sh),
    .in_ready(fifo_rdy),
    .out_valid(fv),
    .out_data(fd),
    .out_ready(pop)
  );

  assign own_up = tx_r.busy & ~tx_r.dn;
  assign own_dn = tx_r.busy & tx_r.dn;

  // host-side receiver: bit rate measured from the calibration word
  always_comb begin
    rx_nxt = rx_r;
    push = 1'b0;
    up_fall = rx_r.prev & ~UP_RX;
    rx_nxt.prev = UP_RX;
    // while replies run hostward the host is silent, so ignore the pin
    if (!eng_r.dir_up && !own_up) begin
      unique case (rx_r.st)
        daisy_link_pkg::R_CALW: if (up_fall) begin
          rx_nxt.cnt = (`BIT_W+3)'(1);
          rx_nxt.falls = '0;
          rx_nxt.st = daisy_link_pkg::R_CALM;
        end
        daisy_link_pkg::R_CALM: begin
          // 55h gives five falling edges two bits apart, first to last eight bits
          rx_nxt.cnt = (`BIT_W+3)'(rx_r.cnt + 1'b1);
          if (up_fall) begin
            rx_nxt.falls = 3'(rx_r.falls + 1'b1);
            if (rx_r.falls == 3'h3) begin
              rx_nxt.bitp = rx_r.cnt[`BIT_W+2:3];
              rx_nxt.st = daisy_link_pkg::R_IDLE;
            end
          end
        end
        daisy_link_pkg::R_IDLE: if (up_fall) begin
          rx_nxt.cnt = (`BIT_W+3)'(rx_r.bitp >> 1);
          rx_nxt.n = '0;
          rx_nxt.st = daisy_link_pkg::R_BITS;
        end
        daisy_link_pkg::R_BITS: begin
          if (rx_r.cnt == '0) begin
            rx_nxt.cnt = (`BIT_W+3)'(rx_r.bitp - 1'b1);
            rx_nxt.n = 4'(rx_r.n + 1'b1);
            if (rx_r.n == 4'h0 && UP_RX) begin
              rx_nxt.st = daisy_link_pkg::R_IDLE; // glitch, not a start
            end else if (rx_r.n == 4'h9) begin
              rx_nxt.st = daisy_link_pkg::R_IDLE;
              push = UP_RX;
            end else if (rx_r.n != 4'h0) begin
              rx_nxt.sh = {UP_RX, rx_r.sh[7:1]};
            end
          end else begin
            rx_nxt.cnt = (`BIT_W+3)'(rx_r.cnt - 1'b1);
          end
        end
      endcase
    end
    if (cal) begin
      rx_nxt.st = daisy_link_pkg::R_CALW;
    end
  end

  // downstream word counter for replies passing through
  always_comb begin
    dn_nxt = dn_r;
    dn_fall = dn_r.prev & ~DN_RX;
    dn_nxt.prev = DN_RX;
    gap_len = (`BIT_W+4)'({rx_r.bitp, 3'h0} + rx_r.bitp + (rx_r.bitp >> 1));
    if (dn_r.gap != '0) begin
      dn_nxt.gap = (`BIT_W+4)'(dn_r.gap - 1'b1);
    end
    if (!eng_r.dir_up) begin
      dn_nxt.words = '0;
      dn_nxt.gap = '0;
    end else if (dn_fall && dn_r.gap == '0 && !own_dn) begin
      dn_nxt.words = 6'(dn_r.words + 1'b1);
      dn_nxt.gap = gap_len; // skip to mid stop bit
    end
  end

  // word transmitter toward either neighbour
  always_comb begin
    tx_nxt = tx_r;
    if (go) begin
      tx_nxt.busy = 1'b1;
      tx_nxt.dn = god;
      tx_nxt.n = 4'hA;
      tx_nxt.cnt = `BIT_W'(rx_r.bitp - 1'b1);
      tx_nxt.sh = {1'b1, gob, 1'b0};
    end else if (tx_r.busy) begin
      if (tx_r.cnt == '0) begin
        tx_nxt.busy = tx_r.n != 4'h1;
        tx_nxt.sh = {1'b1, tx_r.sh[9:1]};
        tx_nxt.n = 4'(tx_r.n - 1'b1);
        tx_nxt.cnt = `BIT_W'(rx_r.bitp - 1'b1);
      end else begin
        tx_nxt.cnt = `BIT_W'(tx_r.cnt - 1'b1);
      end
    end
  end

  // protocol sequencer
  always_comb begin
    eng_nxt = eng_r;
    go = 1'b0;
    god = 1'b0;
    gob = '0;
    pop = 1'b0;
    opc = daisy_link_pkg::opcode_t'(fd);
    eng_nxt.wr = 1'b0;
    eng_nxt.srst = 1'b0;
    eng_nxt.aclr = 1'b0;
    eng_nxt.conv = 1'b0;
    eng_nxt.tmr = `TMR_W'(eng_r.tmr + 1'b1);
    mine = eng_r.addr == eng_r.op.node_address_field;
    part = eng_r.addr <= eng_r.op.node_address_field;
    hit = eng_r.op.global_select_bit ? part : mine;
    rdm = REG_RDATA;
    if (eng_r.ptr == `CFG_PTR) begin
      rdm[`CFG_ONESHOT_BIT] = 1'b0;
    end
    // conversion restarts itself unless shut down
    if (CONV_DONE) begin
      eng_nxt.cbusy = 1'b0;
    end
    if (!eng_r.cbusy && !SHUTDOWN) begin
      eng_nxt.conv = 1'b1;
      eng_nxt.cbusy = 1'b1;
    end
    unique case (eng_r.st)
      daisy_link_pkg::P_OP: if (fv) begin
        pop = 1'b1;
        eng_nxt.op = opc;
        eng_nxt.tmr = '0;
        if (!opc.operation_type_bit) begin
          eng_nxt.st = daisy_link_pkg::P_PTR;
        end else begin
          case (fd)
            `OP_ADDR_INIT: eng_nxt.st = daisy_link_pkg::P_INIT;
            `OP_LAST_POLL: if (eng_r.last) begin
              go = 1'b1;
              gob = {eng_r.addr, `RESP_TAG};
              eng_nxt.st = daisy_link_pkg::P_TXW;
            end else begin
              eng_nxt.need = 6'h1;
              eng_nxt.own = 1'b0;
              eng_nxt.st = daisy_link_pkg::P_FWD;
            end
            `OP_SOFT_RESET: eng_nxt.srst = 1'b1;
            `OP_ALERT_CLR1, `OP_ALERT_CLR2: eng_nxt.aclr = 1'b1;
            default: ; // reserved code: no action
          endcase
        end
      end
      daisy_link_pkg::P_PTR: if (fv) begin
        pop = 1'b1;
        eng_nxt.ptr = fd[3:0];
        eng_nxt.tmr = '0;
        eng_nxt.st = daisy_link_pkg::P_OP;
        if (!eng_r.op.read_not_write_bit) begin
          eng_nxt.st = daisy_link_pkg::P_D0;
        end else if (hit) begin
          // nodes below us answer first, then we add our own
          eng_nxt.need = eng_r.op.global_select_bit ?
            {5'(eng_r.op.node_address_field - eng_r.addr), 1'b0} : 6'h0;
          eng_nxt.own = 1'b1;
          eng_nxt.st = (eng_nxt.need == 6'h0) ? daisy_link_pkg::P_RLO :
            daisy_link_pkg::P_FWD;
        end else if (!eng_r.op.global_select_bit &&
            eng_r.op.node_address_field > eng_r.addr) begin
          eng_nxt.need = 6'h2;
          eng_nxt.own = 1'b0;
          eng_nxt.st = daisy_link_pkg::P_FWD;
        end
      end
      daisy_link_pkg::P_D0: if (fv) begin
        pop = 1'b1;
        eng_nxt.lo = fd;
        eng_nxt.st = daisy_link_pkg::P_D1;
      end
      daisy_link_pkg::P_D1: if (fv) begin
        pop = 1'b1;
        eng_nxt.st = daisy_link_pkg::P_OP;
        if (hit) begin
          eng_nxt.wr = 1'b1;
          eng_nxt.wdata = {fd, eng_r.lo};
          if (eng_r.ptr == `CFG_PTR) begin
            if (eng_nxt.wdata[`CFG_ONESHOT_BIT] && SHUTDOWN) begin
              eng_nxt.conv = 1'b1;
              eng_nxt.cbusy = 1'b1;
            end
            if (eng_nxt.wdata[`CFG_SRST_BIT]) begin
              eng_nxt.srst = 1'b1;
            end
          end
        end
      end
      daisy_link_pkg::P_FWD: begin
        if (dn_r.words >= eng_r.need && dn_r.gap == '0) begin
          eng_nxt.st = eng_r.own ? daisy_link_pkg::P_RLO :
            daisy_link_pkg::P_OP;
        end else if (eng_r.tmr == `TMR_W'(GREAD_TO_CYC - 1)) begin
          eng_nxt.st = daisy_link_pkg::P_OP;
        end
      end
      daisy_link_pkg::P_RLO: begin
        go = 1'b1; // starts at once, well inside 1.5 bits
        gob = rdm[7:0];
        eng_nxt.st = daisy_link_pkg::P_RHI;
      end
      daisy_link_pkg::P_RHI: if (!tx_r.busy) begin
        go = 1'b1;
        gob = rdm[15:8];
        eng_nxt.st = daisy_link_pkg::P_TXW;
      end
      daisy_link_pkg::P_TXW: if (!tx_r.busy) begin
        eng_nxt.st = daisy_link_pkg::P_OP;
      end
      daisy_link_pkg::P_INIT: if (fv) begin
        pop = 1'b1;
        eng_nxt.addr = fd[7:3];
        eng_nxt.lo = fd;
        eng_nxt.last = 1'b1;
        eng_nxt.tmr = '0;
        eng_nxt.st = daisy_link_pkg::P_INITW;
      end
      daisy_link_pkg::P_INITW: if (eng_r.tmr == `TMR_W'(RESP_CYC - 1)) begin
        go = 1'b1;
        gob = {eng_r.addr, eng_r.lo[2:0]};
        eng_nxt.st = daisy_link_pkg::P_INITD;
      end
      daisy_link_pkg::P_INITD: if (!tx_r.busy) begin
        go = 1'b1;
        god = 1'b1;
        gob = {5'(eng_r.addr + 1'b1), eng_r.lo[2:0]};
        eng_nxt.st = daisy_link_pkg::P_INITF;
      end
      daisy_link_pkg::P_INITF: begin
        if (dn_r.words != '0) begin
          eng_nxt.last = 1'b0; // someone answered below us
        end
        if (eng_r.tmr == `TMR_W'(INIT_TO_CYC - 1)) begin
          eng_nxt.st = daisy_link_pkg::P_OP;
        end
      end
    endcase
    eng_nxt.dir_up = eng_nxt.st == daisy_link_pkg::P_FWD ||
      eng_nxt.st == daisy_link_pkg::P_INITF;
    cal = eng_nxt.st == daisy_link_pkg::P_OP &&
      (eng_r.st != daisy_link_pkg::P_OP || (pop && opc.operation_type_bit));
  end

  // pin drivers: own words win, otherwise repeat the other side
  always_comb begin
    pins_nxt.up_oe = own_up | (eng_r.dir_up & ~own_dn);
    pins_nxt.up_tx = own_up ? tx_r.sh[0] : DN_RX;
    pins_nxt.dn_oe = own_dn | ~eng_r.dir_up;
    pins_nxt.dn_tx = own_dn ? tx_r.sh[0] : UP_RX;
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rx_r <= '0;
      tx_r <= '0;
      dn_r <= '0;
      eng_r <= '0;
      pins_r <= daisy_link_pkg::pin_t'(`PINS_RST);
    end else if (CE) begin
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      dn_r <= dn_nxt;
      eng_r <= eng_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign UP_TX = pins_r.up_tx;
  assign UP_OE = pins_r.up_oe;
  assign DN_TX = pins_r.dn_tx;
  assign DN_OE = pins_r.dn_oe;
  assign REG_PTR = eng_r.ptr;
  assign REG_WDATA = eng_r.wdata;
  assign REG_WR = eng_r.wr;
  assign SOFT_RST = eng_r.srst;
  assign ALERT_CLR = eng_r.aclr;
  assign CONV_START = eng_r.conv;
  assign NODE_ADDR = eng_r.addr;
  assign LAST_NODE = eng_r.last;
endmodule : daisy_chain_sensor_link
`default_nettype wire

// File: testbench/link_chk.sv
// port assertions for the daisy-chain node link engine
`timescale 1ns/1ps
`default_nettype none
module link_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic UP_RX,
  input wire logic UP_TX,
  input wire logic UP_OE,
  input wire logic DN_TX,
  input wire logic DN_OE,
  input wire logic SHUTDOWN,
  input wire logic CONV_DONE,
  input wire logic [3:0] REG_PTR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic SOFT_RST,
  input wire logic CONV_START,
  input wire logic [4:0] NODE_ADDR,
  input wire logic LAST_NODE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // line idle and node unaddressed right after reset
  reset_idle_a:
    assert property ($fell(RST) |-> UP_TX && !UP_OE && DN_OE
      && NODE_ADDR == 5'h00 && !LAST_NODE)
    else $error("link not idle after reset");
  // host low bits reach the next node one cycle later while the downstream side is driven
  host_repeat_a:
    assert property (CE && $past(CE) && !$past(UP_RX) && DN_OE
      && $past(DN_OE) |-> !DN_TX)
    else $error("downstream copy lost");
  dn_drive_a:
    assert property (!UP_OE |-> DN_OE)
    else $error("no direction driven");
  // register strobe: single cycle, pointer settled, node quiet upstream
  wr_pulse_a:
    assert property (REG_WR |=> !REG_WR)
    else $error("write strobe too long");
  ptr_stable_a:
    assert property (REG_WR |-> $stable(REG_PTR))
    else $error("pointer moved under write");
  wr_quiet_a:
    assert property (REG_WR |-> !UP_OE)
    else $error("write while replying");
  // config side effects follow the write, and a conversion restarts after CONV_DONE, within two cycles
  srst_cfg_a:
    assert property (REG_WR && REG_PTR == 4'h1 && REG_WDATA[1]
      |-> ##[0:2] SOFT_RST)
    else $error("soft reset bit ignored");
  oneshot_conv_a:
    assert property (REG_WR && REG_PTR == 4'h1 && REG_WDATA[12] && SHUTDOWN
      |-> ##[0:2] CONV_START)
    else $error("single conversion not started");
  conv_cont_a:
    assert property (CE && CONV_DONE && !SHUTDOWN |-> ##[0:2] CONV_START)
    else $error("continuous conversion stopped");
endmodule : link_chk

bind daisy_chain_sensor_link link_chk chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .CE(CE), .UP_RX(UP_RX), .UP_TX(UP_TX), .UP_OE(UP_OE), .DN_TX(DN_TX),
  .DN_OE(DN_OE), .SHUTDOWN(SHUTDOWN), .CONV_DONE(CONV_DONE),
  .REG_PTR(REG_PTR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .SOFT_RST(SOFT_RST), .CONV_START(CONV_START), .NODE_ADDR(NODE_ADDR),
  .LAST_NODE(LAST_NODE));
`default_nettype wire

// File: testbench/link_end.sv
// serial end of the chain: host or next node, 10-bit words on one line
`timescale 1ns/1ps
`default_nettype none
module link_end #(
  parameter int BITP = 16
) (
  input wire logic clk,
  input wire logic line,
  output logic tx
);
  // released line rests high
  initial tx = 1'b1;

  // low start bit, data lsb first, high stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] w;
    w = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      tx = w[i];
      repeat (BITP - 1) @(negedge clk);
    end
  endtask : send

  // only a fall this end did not make counts as a start bit
  task automatic recv(output logic [7:0] b);
    logic prev;
    int t;
    prev = 1'b0;
    b = 'x;
    for (t = 0; t < 3000; t++) begin
      @(posedge clk);
      if (prev && !line && tx) break;
      prev = line;
    end
    if (t < 3000) begin
      repeat (BITP / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BITP) @(posedge clk);
        b[i] = line;
      end
      repeat (BITP) @(posedge clk);
      if (line !== 1'b1) b = 'x; // framing lost
    end
  endtask : recv
endmodule : link_end
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench of the daisy-chain node link engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int BITP = 16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic shutdown = 1'b0;
  logic conv_done = 1'b0;
  logic ce = 1'b1;
  logic up_tx, up_oe, dn_tx, dn_oe, reg_wr, soft_rst, alert_clr, conv_start;
  logic last_node;
  logic up_q = 1'b0;
  logic [3:0] reg_ptr, w_ptr;
  logic [4:0] node_addr;
  logic [15:0] reg_wdata, reg_rdata, w_dat, rd_v, got;
  logic [7:0] ub, db;
  wire host_tx, down_tx, up_w, dn_w;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_wr = 0, n_srst = 0, n_aclr = 0, n_conv = 0, n_up = 0, k;
  logic [7:0] wop [4] = '{8'h08, 8'h10, 8'h19, 8'h01};
  logic [7:0] cop [4] = '{8'h5D, 8'hB5, 8'h75, 8'h0D};
  int whits [4] = '{1, 1, 2, 2};

  always #2.5 clk_sys = ~clk_sys;
  // wire levels: the enabled party drives, else the partner model
  assign up_w = up_oe ? up_tx : host_tx;
  assign dn_w = dn_oe ? dn_tx : down_tx;
  // register file stand-in: pointer shows in the top nibble
  assign reg_rdata = {reg_ptr, 12'hC35};

  daisy_chain_sensor_link #(.RESP_CYC(200), .INIT_TO_CYC(4000),
    .GREAD_TO_CYC(2000)) dut (.CLK_SYS(clk_sys), .RST(rst),
    .CE(ce), .UP_RX(up_w), .UP_TX(up_tx), .UP_OE(up_oe), .DN_RX(dn_w),
    .DN_TX(dn_tx), .DN_OE(dn_oe), .SHUTDOWN(shutdown),
    .CONV_DONE(conv_done), .REG_RDATA(reg_rdata), .REG_PTR(reg_ptr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .SOFT_RST(soft_rst),
    .ALERT_CLR(alert_clr), .CONV_START(conv_start),
    .NODE_ADDR(node_addr), .LAST_NODE(last_node));
  link_end #(.BITP(BITP)) host (.clk(clk_sys), .line(up_w), .tx(host_tx));
  link_end #(.BITP(BITP)) down (.clk(clk_sys), .line(dn_w), .tx(down_tx));

  // pulse counters and hang guard; pulses seen one edge after they rise
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    up_q <= up_oe;
    if (reg_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      w_ptr <= reg_ptr;
      w_dat <= reg_wdata;
    end
    if (soft_rst === 1'b1) n_srst <= n_srst + 1;
    if (alert_clr === 1'b1) n_aclr <= n_aclr + 1;
    if (conv_start === 1'b1) n_conv <= n_conv + 1;
    if (up_oe === 1'b1 && up_q === 1'b0) n_up <= n_up + 1;
    if (cyc == 60000) begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // calibration, opcode, pointer for address operations only
  task automatic head(input logic [7:0] op, input logic [7:0] ptr);
    host.send(8'h55);
    host.send(op);
    if (!op[2]) host.send(ptr);
  endtask : head

  task automatic wr(input logic [7:0] op, input logic [3:0] p,
    input logic [15:0] d);
    head(op, {4'h0, p});
    host.send(d[7:0]);
    host.send(d[15:8]);
    repeat (3 * BITP) @(negedge clk_sys);
  endtask : wr

  // reply may start while the pointer stop bit is still going out
  task automatic rd(input logic [7:0] op, input logic [3:0] p,
    output logic [15:0] d);
    fork
      head(op, {4'h0, p});
      begin
        host.recv(d[7:0]);
        host.recv(d[15:8]);
      end
    join
    repeat (3 * BITP) @(negedge clk_sys);
  endtask : rd

  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({8'h0, up_oe, dn_oe, last_node, node_addr}, 16'h0040);
    chk(16'(n_conv), 16'h0001);
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(16'(n_conv), 16'h0002);
    // clock enable low: a finished conversion goes unseen, no restart
    ce = 1'b0;
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    repeat (4) @(negedge clk_sys);
    ce = 1'b1;
    chk(16'(n_conv), 16'h0002);
    conv_done = 1'b1;
    @(negedge clk_sys);
    conv_done = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(16'(n_conv), 16'h0003);
    // address init: first node 1, hostward then next node's word
    head(8'h95, 8'h00);
    host.send(8'h08);
    fork
      host.recv(ub);
      begin
        // own hostward word is copied downstream before the next address
        down.recv(db);
        chk({8'h00, db}, 16'h0008);
        down.recv(db);
      end
    join
    chk({ub, db}, 16'h0810);
    chk({last_node, 2'b00, node_addr, 8'h00}, 16'h8100);
    repeat (4000) @(negedge clk_sys);
    // last node answers the poll, proving the line came back
    fork
      head(8'h57, 8'h00);
      host.recv(ub);
    join
    chk({8'h00, ub}, 16'h0008);
    repeat (3 * BITP) @(negedge clk_sys);
    // individual hit, miss, global hit, global below node
    foreach (wop[i]) begin
      wr(wop[i], 4'h2, 16'hA5C0 + 16'(i));
      chk(16'(n_wr), 16'(whits[i]));
    end
    chk(w_dat, 16'hA5C2);
    chk({12'h000, w_ptr}, 16'h0002);
    rd(8'h0A, 4'h3, rd_v);
    chk(rd_v, 16'h3C35);
    rd(8'h0A, 4'h1, rd_v);
    chk(rd_v, 16'h0C35);
    // global read to 2: next node's pair forwarded, then our own
    fork
      head(8'h13, 8'h03);
      begin
        host.recv(got[7:0]);
        host.recv(got[15:8]);
        host.recv(rd_v[7:0]);
        host.recv(rd_v[15:8]);
      end
      begin
        repeat (32 * BITP) @(negedge clk_sys);
        down.send(8'hEF);
        down.send(8'hBE);
      end
    join
    chk(got, 16'hBEEF);
    chk(rd_v, 16'h3C35);
    repeat (3 * BITP) @(negedge clk_sys);
    // shutdown: trigger and soft-reset bits in one config write
    shutdown = 1'b1;
    wr(8'h08, 4'h1, 16'h1002);
    chk(16'(n_conv), 16'h0004);
    chk(16'(n_srst), 16'h0001);
    // soft reset, both alert clears plus one reserved: none of them is answered
    k = n_up;
    foreach (cop[i]) begin
      head(cop[i], 8'h00);
      repeat (3 * BITP) @(negedge clk_sys);
    end
    chk(16'(n_srst), 16'h0002);
    chk(16'(n_aclr), 16'h0002);
    chk(16'(n_up - k), 16'h0000);
    // global read past the chain end: halts, times out, node usable again
    head(8'h1B, 8'h03);
    repeat (2100) @(negedge clk_sys);
    rd(8'h0A, 4'h3, rd_v);
    chk(rd_v, 16'h3C35);
    conclude();
  end
endmodule : tb
`default_nettype wire
